// [wdr_cfg.svh]
// Offsets, field positions, reset values and timing counts of the watchdog and reset sequencer
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WDR_ADDR_CAUSE 8'h00
`define WDR_ADDR_OPTS 8'h01
`define WDR_ADDR_STAT 8'h02

// ----------------------------------------
// Reset cause flag positions
// ----------------------------------------
`define WDR_CAUSE_POR 7
`define WDR_CAUSE_PIN 6
`define WDR_CAUSE_WDOG 5
`define WDR_CAUSE_ILOP 4
`define WDR_CAUSE_ILAD 3
`define WDR_CAUSE_CLKGEN 1

// ----------------------------------------
// Options fields and reset values
// ----------------------------------------
`define WDR_OPT_ENABLE 7
`define WDR_OPT_PERIOD 6
`define WDR_OPTS_RESET 8'hC0
`define WDR_CAUSE_RESET 8'h80

// ----------------------------------------
// Reset pin timing in bus cycles
// ----------------------------------------
`define WDR_PIN_DRIVE_CYCLES 34
`define WDR_PIN_SAMPLE_CYCLES 38

`endif

// [wdr_pkg.sv]
// Types shared by the watchdog and reset sequencer
package wdr_pkg;

    // ----------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_RUN     = 4'h1,
        ST_DRIVE   = 4'h2,
        ST_RELEASE = 4'h4,
        ST_HOLD    = 4'h8
    } wdr_state_t;

endpackage

// [wdr_top.sv]
// Watchdog timer and reset entry sequencer with its register port
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "wdr_cfg.svh"


module wdr_top #(
    parameter int WDOG_LONG_EXP = 18,
    parameter int WDOG_SHORT_EXP = 13,
    parameter int CNT_W = 18
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic bdm_active,
    input wire logic bdm_reset_req,
    input wire logic illegal_opcode,
    input wire logic illegal_addr,
    input wire logic clkgen_loss_lock,
    input wire logic clkgen_loss_clock,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    output logic sys_reset,
    output logic clkgen_self_clock
);

    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    localparam logic [5:0] DRIVE_LAST = 6'(`WDR_PIN_DRIVE_CYCLES - 1);
    localparam logic [5:0] SAMPLE_LAST = 6'(`WDR_PIN_SAMPLE_CYCLES - 1);

    // ----------------------------------------
    // Terminal count for a period select
    // ----------------------------------------
    function automatic logic [CNT_W-1:0] term_of(input logic long_sel);
        logic [CNT_W:0] span;
        begin
            if (long_sel) begin
                span = (CNT_W+1)'(1) << WDOG_LONG_EXP;
            end else begin
                span = (CNT_W+1)'(1) << WDOG_SHORT_EXP;
            end
            term_of = CNT_W'(span - (CNT_W+1)'(1));
        end
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    wdr_pkg::wdr_state_t state_q;
    wdr_pkg::wdr_state_t state_d;
    logic bus_phase_q;
    logic [5:0] seq_cnt_q;
    logic [5:0] seq_cnt_d;
    logic [CNT_W-1:0] wdog_cnt_q;
    logic [CNT_W-1:0] wdog_cnt_d;
    logic wdog_fire_q;
    logic [7:0] opts_q;
    logic [7:0] opts_d;
    logic opts_locked_q;
    logic [7:0] cause_q;
    logic [7:0] cause_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rst_pin_out_q;
    logic pin_oe_n_q;
    logic sys_reset_q;
    logic self_clock_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire bus_tick = clk_en & bus_phase_q;
    wire in_run = (state_q == wdr_pkg::ST_RUN);
    wire hit_cause = (reg_addr == `WDR_ADDR_CAUSE);
    wire hit_opts = (reg_addr == `WDR_ADDR_OPTS);
    wire hit_stat = (reg_addr == `WDR_ADDR_STAT);
    wire wr_service = reg_wr & hit_cause;
    wire wr_opts = reg_wr & hit_opts & ~opts_locked_q;
    wire wdog_en = opts_q[`WDR_OPT_ENABLE];
    wire wdog_long = opts_q[`WDR_OPT_PERIOD];
    wire wdog_active = wdog_en & ~bdm_active & in_run;
    wire [CNT_W-1:0] wdog_term = term_of(wdog_long);
    // At or past term, so a late switch to the short period still fires
    wire wdog_at_term = (wdog_cnt_q >= wdog_term);
    wire clkgen_lost = clkgen_loss_lock | clkgen_loss_clock;
    wire pin_ext_low = ~rst_pin_in;
    wire any_source = wdog_fire_q | illegal_opcode | illegal_addr
                    | clkgen_lost | bdm_reset_req | pin_ext_low;
    wire drive_done = bus_tick & (seq_cnt_q == DRIVE_LAST);
    wire sample_now = bus_tick & (seq_cnt_q == SAMPLE_LAST);

    // ----------------------------------------
    // Cause of a fresh reset, one flag only
    // ----------------------------------------
    logic [7:0] entry_cause;
    always_comb begin
        entry_cause = 8'h00;
        if (clkgen_lost) begin
            entry_cause[`WDR_CAUSE_CLKGEN] = 1'b1;
        end else if (wdog_fire_q) begin
            entry_cause[`WDR_CAUSE_WDOG] = 1'b1;
        end else if (illegal_opcode) begin
            entry_cause[`WDR_CAUSE_ILOP] = 1'b1;
        end else if (illegal_addr) begin
            entry_cause[`WDR_CAUSE_ILAD] = 1'b1;
        end else if (bdm_reset_req) begin
            // Debug forced reset owns no flag
            entry_cause = 8'h00;
        end else if (pin_ext_low) begin
            entry_cause[`WDR_CAUSE_PIN] = 1'b1;
        end
    end

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        seq_cnt_d = seq_cnt_q;
        case (state_q)
            wdr_pkg::ST_RUN: begin
                if (any_source) begin
                    state_d = wdr_pkg::ST_DRIVE;
                    seq_cnt_d = 6'h00;
                end
            end
            wdr_pkg::ST_DRIVE: begin
                if (drive_done) begin
                    state_d = wdr_pkg::ST_RELEASE;
                    seq_cnt_d = 6'h00;
                end else if (bus_tick) begin
                    seq_cnt_d = seq_cnt_q + 6'h01;
                end
            end
            wdr_pkg::ST_RELEASE: begin
                if (sample_now) begin
                    // Pin still low: someone outside holds it
                    if (pin_ext_low) begin
                        state_d = wdr_pkg::ST_HOLD;
                    end else begin
                        state_d = wdr_pkg::ST_RUN;
                    end
                    seq_cnt_d = 6'h00;
                end else if (bus_tick) begin
                    seq_cnt_d = seq_cnt_q + 6'h01;
                end
            end
            wdr_pkg::ST_HOLD: begin
                if (!pin_ext_low) begin
                    state_d = wdr_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = wdr_pkg::ST_DRIVE;
                seq_cnt_d = 6'h00;
            end
        endcase
    end

    // ----------------------------------------
    // Watchdog counter next value
    // ----------------------------------------
    // Cleared rather than frozen when idle, so debug exit starts a full period
    always_comb begin
        wdog_cnt_d = wdog_cnt_q;
        if (!wdog_active || wr_service) begin
            wdog_cnt_d = '0;
        end else if (bus_tick && !wdog_at_term) begin
            wdog_cnt_d = wdog_cnt_q + CNT_W'(1);
        end
    end

    // ----------------------------------------
    // Options register next value
    // ----------------------------------------
    // Options and lock return to defaults in every reset, not only power-on
    always_comb begin
        opts_d = opts_q;
        if (!in_run) begin
            opts_d = `WDR_OPTS_RESET;
        end else if (wr_opts) begin
            opts_d = 8'h00;
            opts_d[`WDR_OPT_ENABLE] = reg_wdata[`WDR_OPT_ENABLE];
            opts_d[`WDR_OPT_PERIOD] = reg_wdata[`WDR_OPT_PERIOD];
        end
    end

    // ----------------------------------------
    // Reset cause next value
    // ----------------------------------------
    // No write path at all: service writes only touch the counter
    always_comb begin
        cause_d = cause_q;
        if (in_run && any_source) begin
            cause_d = entry_cause;
        end else if (state_q == wdr_pkg::ST_RELEASE && sample_now && pin_ext_low) begin
            cause_d = 8'h00;
            cause_d[`WDR_CAUSE_PIN] = 1'b1;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd && hit_cause) begin
            rdata_d = cause_q;
        end else if (reg_rd && hit_opts) begin
            rdata_d = opts_q;
        end else if (reg_rd && hit_stat) begin
            rdata_d = {opts_locked_q, 3'h0, state_q};
        end
    end

    // ----------------------------------------
    // Bus rate divider
    // ----------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bus_phase_q <= 1'b0;
        end else if (clk_en) begin
            bus_phase_q <= ~bus_phase_q;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Power-on enters straight into the pin drive phase
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= wdr_pkg::ST_DRIVE;
            seq_cnt_q <= 6'h00;
        end else if (clk_en) begin
            state_q <= state_d;
            seq_cnt_q <= seq_cnt_d;
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wdog_cnt_q <= '0;
        end else if (clk_en) begin
            wdog_cnt_q <= wdog_cnt_d;
        end
    end

    // Timeout request, dropped once reset is under way
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wdog_fire_q <= 1'b0;
        end else if (clk_en) begin
            wdog_fire_q <= wdog_active & ~wr_service & bus_tick & wdog_at_term;
        end
    end

    // ----------------------------------------
    // Options register and write-once lock
    // ----------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            opts_q <= `WDR_OPTS_RESET;
        end else if (clk_en) begin
            opts_q <= opts_d;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            opts_locked_q <= 1'b0;
        end else if (clk_en) begin
            opts_locked_q <= in_run & (opts_locked_q | (reg_wr & hit_opts));
        end
    end

    // ----------------------------------------
    // Reset cause
    // ----------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cause_q <= `WDR_CAUSE_RESET;
        end else if (clk_en) begin
            cause_q <= cause_d;
        end
    end

    // ----------------------------------------
    // Register port read data
    // ----------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Pin and system outputs
    // ----------------------------------------
    // Pin is open drain: output level stays low, only the enable moves
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rst_pin_out_q <= 1'b0;
            pin_oe_n_q <= 1'b0;
            sys_reset_q <= 1'b1;
            self_clock_q <= 1'b1;
        end else if (clk_en) begin
            rst_pin_out_q <= 1'b0;
            pin_oe_n_q <= (state_d != wdr_pkg::ST_DRIVE);
            sys_reset_q <= (state_d != wdr_pkg::ST_RUN);
            self_clock_q <= (state_d != wdr_pkg::ST_RUN);
        end
    end

    assign reg_rdata = rdata_q;
    assign rst_pin_out = rst_pin_out_q;
    assign rst_pin_oe_n = pin_oe_n_q;
    assign sys_reset = sys_reset_q;
    assign clkgen_self_clock = self_clock_q;

endmodule

// [wdr_chk.sv]
// Port assertions for the watchdog and reset sequencer
`timescale 1ns/1ps
module wdr_chk #(
    parameter int WDOG_LONG_EXP = 18,
    parameter int WDOG_SHORT_EXP = 13,
    parameter int CNT_W = 18
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic bdm_active,
    input wire logic bdm_reset_req,
    input wire logic illegal_opcode,
    input wire logic illegal_addr,
    input wire logic clkgen_loss_lock,
    input wire logic clkgen_loss_clock,
    input wire logic rst_pin_in,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    input wire logic sys_reset,
    input wire logic clkgen_self_clock
);
    // Timeouts in clocks, one bus tick is two clocks
    localparam int TL = 2 << WDOG_LONG_EXP;
    localparam int TS = 2 << WDOG_SHORT_EXP;
    logic en_q;
    logic per_q;
    logic lk_q;
    logic hold_q;
    logic [31:0] run_q;
    logic [31:0] drv_q;
    logic [31:0] rel_q;
    wire opt_wr = clk_en && reg_wr && reg_addr == 8'h01 && !lk_q;
    wire svc = clk_en && reg_wr && reg_addr == 8'h00;
    wire [31:0] tmo = per_q ? TL : TS;
    // Shadow options rebuilt on every reset entry
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            en_q <= 1'b1;
            per_q <= 1'b1;
            lk_q <= 1'b0;
            run_q <= '0;
        end else if (sys_reset) begin
            en_q <= 1'b1;
            per_q <= 1'b1;
            lk_q <= 1'b0;
            run_q <= '0;
        end else begin
            if (opt_wr) begin
                en_q <= reg_wdata[7];
                per_q <= reg_wdata[6];
                lk_q <= 1'b1;
            end
            // Frozen clocks do not age the watchdog
            run_q <= (bdm_active || svc) ? '0 : run_q + 32'(clk_en);
        end
    end
    // Release count freezes once someone else holds the pin
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            drv_q <= '0;
            rel_q <= '0;
            hold_q <= 1'b0;
        end else begin
            drv_q <= rst_pin_oe_n ? '0 : drv_q + 32'd1;
            hold_q <= sys_reset && (hold_q || (rst_pin_oe_n && !rst_pin_in));
            rel_q <= !sys_reset ? '0 : rel_q + 32'(rst_pin_oe_n && !hold_q);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    pin_drive_a: assert property ($rose(rst_pin_oe_n) |-> drv_q inside {[67:69]})
        else $error("pin drive length wrong");
    pin_sample_a: assert property ($fell(sys_reset) |-> hold_q || rel_q inside {[75:77]})
        else $error("pin sample time wrong");
    pin_hold_a: assert property (sys_reset && rst_pin_oe_n && !rst_pin_in |=> sys_reset)
        else $error("left reset with pin held low");
    open_drain_a: assert property (!rst_pin_oe_n |-> !rst_pin_out && sys_reset)
        else $error("pin driven outside reset");
    entry_drive_a: assert property ($rose(sys_reset) |-> !rst_pin_oe_n)
        else $error("reset entry without pin drive");
    self_clock_a: assert property (clkgen_self_clock == sys_reset)
        else $error("self clock request wrong");
    src_entry_a: assert property (!sys_reset && (illegal_opcode || illegal_addr ||
        clkgen_loss_lock || clkgen_loss_clock) |-> ##[1:3] sys_reset)
        else $error("reset source ignored");
    wdog_bound_a: assert property (en_q && !sys_reset |-> run_q <= tmo + 32'd6)
        else $error("watchdog overran its timeout");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
endmodule

bind wdr_top wdr_chk #(.WDOG_LONG_EXP(WDOG_LONG_EXP), .WDOG_SHORT_EXP(WDOG_SHORT_EXP),
    .CNT_W(CNT_W)) chk_u (.clock(clock), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bdm_active(bdm_active), .bdm_reset_req(bdm_reset_req),
    .illegal_opcode(illegal_opcode), .illegal_addr(illegal_addr),
    .clkgen_loss_lock(clkgen_loss_lock), .clkgen_loss_clock(clkgen_loss_clock),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
    .sys_reset(sys_reset), .clkgen_self_clock(clkgen_self_clock));

// [wdr_pin_model.sv]
// Reset pin wire with pull-up and an outside party that may hold it low
`timescale 1ns/1ps
module wdr_pin_model (
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    input wire logic ext_hold,
    output logic rst_pin_in
);
    // Pull-up wins only when nobody pulls the wire low
    assign rst_pin_in = !((!rst_pin_oe_n && !rst_pin_out) || ext_hold);
endmodule

// [wdr_tb.sv]
// Self-checking bench for the watchdog and reset sequencer
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bdm_active = 1'b0;
    logic ext_hold = 1'b0;
    logic [4:0] src = 5'h00;
    logic [7:0] reg_rdata;
    logic rst_pin_in;
    logic rst_pin_out;
    logic rst_pin_oe_n;
    logic sys_reset;
    logic clkgen_self_clock;
    logic [7:0] exp_c [5] = '{8'h10, 8'h08, 8'h02, 8'h02, 8'h00};
    int mismatches = 0;
    int check_count = 0;

    always #12.5 clock = ~clock;

    // Short exponents keep timeouts at 512 and 64 clocks
    wdr_top #(.WDOG_LONG_EXP(8), .WDOG_SHORT_EXP(5), .CNT_W(18)) dut_u (
        .clock(clock), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bdm_active(bdm_active), .bdm_reset_req(src[0]), .illegal_opcode(src[4]),
        .illegal_addr(src[3]), .clkgen_loss_lock(src[2]), .clkgen_loss_clock(src[1]),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .sys_reset(sys_reset), .clkgen_self_clock(clkgen_self_clock));
    wdr_pin_model pin_u (.rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .ext_hold(ext_hold), .rst_pin_in(rst_pin_in));

    task automatic wrap_up;
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp);
    endtask
    // Waits up to hi cycles for reset; want=0 means reset must stay away
    task automatic watch(input int lo, input int hi, input logic want);
        int n;
        n = 0;
        #1;
        while (sys_reset !== 1'b1 && n < hi) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk_bit(n >= lo && sys_reset === want, 1'b1);
    endtask
    task automatic run_up;
        int n;
        n = 0;
        while (sys_reset !== 1'b0 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk_bit(sys_reset, 1'b0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_defaults;
        run_up;
        rd_chk(8'h00, 8'h80);
        rd_chk(8'h01, 8'hC0);
        rd_chk(8'h02, 8'h01);
        rd_chk(8'h05, 8'h00);
    endtask
    task automatic s_service;
        repeat (3) begin
            watch(400, 400, 1'b0);
            wr(8'h00, 8'hA5);
        end
        rd_chk(8'h00, 8'h80);
        watch(495, 530, 1'b1);
        run_up;
        rd_chk(8'h00, 8'h20);
    endtask
    task automatic s_short;
        wr(8'h01, 8'h80);
        rd_chk(8'h01, 8'h80);
        watch(45, 75, 1'b1);
        run_up;
        rd_chk(8'h01, 8'hC0);
    endtask
    // Writes while the clock enable is low must be lost
    task automatic s_freeze;
        @(posedge clock);
        clk_en <= 1'b0;
        wr(8'h01, 8'h00);
        clk_en <= 1'b1;
        rd_chk(8'h01, 8'hC0);
        rd_chk(8'h02, 8'h01);
    endtask
    task automatic s_lock;
        wr(8'h01, 8'h00);
        wr(8'h01, 8'hC0);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'h81);
        watch(1200, 1200, 1'b0);
    endtask
    task automatic s_sources;
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            src <= 5'h10 >> i;
            @(posedge clock);
            src <= 5'h00;
            #1;
            chk_bit(sys_reset, 1'b1);
            run_up;
            rd_chk(8'h00, exp_c[i]);
        end
    endtask
    task automatic s_bdm;
        @(posedge clock);
        bdm_active <= 1'b1;
        watch(1200, 1200, 1'b0);
        @(posedge clock);
        bdm_active <= 1'b0;
        watch(495, 530, 1'b1);
        run_up;
    endtask
    task automatic s_pin;
        @(posedge clock);
        ext_hold <= 1'b1;
        watch(1, 5, 1'b1);
        repeat (300) @(posedge clock);
        #1;
        chk_bit(sys_reset, 1'b1);
        @(posedge clock);
        ext_hold <= 1'b0;
        run_up;
        rd_chk(8'h00, 8'h40);
    endtask
    task automatic s_again;
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        run_up;
        rd_chk(8'h00, 8'h80);
    endtask

    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        s_defaults;
        s_service;
        s_short;
        s_freeze;
        s_lock;
        s_sources;
        s_bdm;
        s_pin;
        s_again;
        wrap_up;
    end
    // Whole run is near 6500 clocks, so this only cuts a hang
    initial begin
        #2_000_000;
        mismatches++;
        wrap_up;
    end
endmodule
